// ==== mfhf_fwd_decide.sv ====
// Per-packet routing decision: firmware delivery and host copy
`timescale 1ns/1ps
`default_nettype none
module mfhf_fwd_decide (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pkt_valid,
    input wire logic [24:0] hits,
    input wire logic icmpv6_hit,
    input wire logic [24:0] fwd_mask,
    input wire logic recv_en,
    input wire logic host_global_en,
    output logic decision_valid,
    output logic fw_route,
    output logic host_copy
);
    logic valid_q, valid_d;
    logic route_q, route_d;
    logic host_q, host_d;
    always_comb
    begin
        valid_d = pkt_valid;
        route_d = pkt_valid && recv_en && ((|hits) || icmpv6_hit);
        host_d = pkt_valid && recv_en && host_global_en && (|(hits & fwd_mask));
    end
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            valid_q <= 1'b0;
            route_q <= 1'b0;
            host_q <= 1'b0;
        end
        else
        begin
            valid_q <= valid_d;
            route_q <= route_d;
            host_q <= host_d;
        end
    end
    assign decision_valid = valid_q;
    assign fw_route = route_q;
    assign host_copy = host_q;

    a_no_recv_route: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && !recv_en |=> !fw_route && !host_copy)
        else $error("packet routed while receive disabled");
    a_global_gate: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && !host_global_en |=> !host_copy)
        else $error("host copy without global enable");
    a_host_any_hit: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && recv_en && host_global_en && (|(hits & fwd_mask)) |=> host_copy && fw_route)
        else $error("masked hit not copied to host");
    a_copy_needs_route: assert property (@(posedge mclk) disable iff (!rstn)
        host_copy |-> fw_route && decision_valid && (|($past(hits) & $past(fwd_mask))))
        else $error("host copy without a masked firmware route");
endmodule // mfhf_fwd_decide
`default_nettype wire

// ==== mfhf_pkg.sv ====
// Constants for the management filter control and host-forward register bank
package mfhf_pkg;
    localparam int ADDR_W = 16;
    localparam int NFILT = 25;
    localparam logic [15:0] OFS_MAIN_CTRL = 16'h0018;
    localparam logic [15:0] OFS_CTRL_TWO = 16'h001C;
    localparam logic [15:0] OFS_FWD_MASK = 16'h0020;
    localparam logic [15:0] OFS_HOST_CTRL_TWO = 16'h5824;
    localparam logic [15:0] OFS_HOST_FWD_MASK = 16'h5860;
    localparam logic [31:0] MAIN_CTRL_WMASK = 32'h0022_0000;
    localparam logic [31:0] CTRL_TWO_WMASK = 32'h0006_F30F;
    localparam logic [31:0] FWD_MASK_WMASK = 32'h01FF_FFFF;
    localparam logic [31:0] MAIN_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_TWO_RST = 32'h0000_0000;
    localparam logic [31:0] FWD_MASK_RST = 32'h0000_0000;
    localparam int BIT_RECV_EN = 17;
    localparam int BIT_HOST_GLOBAL = 21;
    localparam int POS_MODE4 = 0;
    localparam int POS_MODE5 = 2;
    localparam int BIT_SIDE4 = 8;
    localparam int BIT_SIDE5 = 9;
    localparam int POS_LOW_IPV6 = 12;
    localparam int BIT_ICMPV6 = 17;
    localparam int BIT_ICMPV4 = 18;
    localparam int HIT_LOW_IPV6 = 18;
    localparam int HIT_FLEX4 = 22;
    localparam int HIT_ICMPV4 = 24;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_UDP = 2'h1;
    localparam logic [1:0] MODE_TCP = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    typedef enum logic [1:0] {
        MFHF_IDLE = 2'b01,
        MFHF_ACK = 2'b10
    } mfhf_bus_state_t;
endpackage

// ==== mfhf_pkt_model.sv ====
// Filter engine stand-in that presents one packet's match results
`timescale 1ns/1ps
`default_nettype none
module mfhf_pkt_model (
    input wire logic mclk,
    output logic pkt_valid,
    output logic [24:0] filter_hit,
    output logic [1:0] flex_dst_hit,
    output logic [1:0] flex_src_hit,
    output logic pkt_udp,
    output logic pkt_tcp,
    output logic icmpv6_hit
);
    initial
    begin
        pkt_valid = 1'b0;
        {filter_hit, flex_dst_hit, flex_src_hit, pkt_udp, pkt_tcp, icmpv6_hit} = '0;
    end
    // Stale lines go inverted so nothing may lean on them between packets
    task automatic send(input logic [31:0] v);
        @(posedge mclk);
        pkt_valid <= 1'b1;
        {filter_hit, flex_dst_hit, flex_src_hit, pkt_udp, pkt_tcp, icmpv6_hit} <= v;
        @(posedge mclk);
        pkt_valid <= 1'b0;
        {filter_hit, flex_dst_hit, flex_src_hit, pkt_udp, pkt_tcp, icmpv6_hit} <= ~v;
    endtask
endmodule // mfhf_pkt_model
`default_nettype wire

// ==== mfhf_port_mode.sv ====
// Flexible port filter protocol and side decode
`timescale 1ns/1ps
`default_nettype none
module mfhf_port_mode (
    input wire logic [1:0] mode,
    input wire logic side_src,
    input wire logic dst_hit,
    input wire logic src_hit,
    input wire logic pkt_udp,
    input wire logic pkt_tcp,
    output logic hit
);
    logic udp_ok;
    logic tcp_ok;
    logic port_ok;
    always_comb
    begin
        udp_ok = (mode == mfhf_pkg::MODE_UDP) || (mode == mfhf_pkg::MODE_BOTH);
        tcp_ok = (mode == mfhf_pkg::MODE_TCP) || (mode == mfhf_pkg::MODE_BOTH);
        port_ok = side_src ? src_hit : dst_hit;
        hit = port_ok && ((udp_ok && pkt_udp) || (tcp_ok && pkt_tcp));
    end
endmodule // mfhf_port_mode
`default_nettype wire

// ==== mfhf_top.sv ====
// Management filter control and host-forward register bank with Avalon-MM slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module mfhf_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pkt_valid,
    input wire logic [24:0] filter_hit,
    input wire logic [1:0] flex_dst_hit,
    input wire logic [1:0] flex_src_hit,
    input wire logic pkt_udp,
    input wire logic pkt_tcp,
    input wire logic icmpv6_hit,
    output logic [1:0] flex_port_filter_4_mode,
    output logic [1:0] flex_port_filter_5_mode,
    output logic [1:0] port_side_select,
    output logic [3:0] low_ipv6_addr_filter,
    output logic icmpv6_filter_en,
    output logic ipv4_control_msg_filter,
    output logic recv_to_firmware_enable,
    output logic host_forward_global_enable,
    output logic decision_valid,
    output logic fw_route,
    output logic host_copy
);
    mfhf_pkg::mfhf_bus_state_t state_q, state_d;
    logic [31:0] main_q, main_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] bmask;
    logic [31:0] rsel;
    logic req;
    logic wr_take;
    logic [24:0] en_vec;
    logic [24:0] hit_gated;
    logic [1:0] flex_hit;

    assign req = avs_read || avs_write;
    // One wait cycle gives read data time to settle in a flop
    assign avs_waitrequest = req && (state_q != mfhf_pkg::MFHF_ACK);
    assign wr_take = avs_write && (state_q == mfhf_pkg::MFHF_ACK);

    always_comb
    begin
        case (state_q)
            mfhf_pkg::MFHF_IDLE: state_d = req ? mfhf_pkg::MFHF_ACK : mfhf_pkg::MFHF_IDLE;
            mfhf_pkg::MFHF_ACK: state_d = mfhf_pkg::MFHF_IDLE;
            default: state_d = mfhf_pkg::MFHF_IDLE;
        endcase
    end

    always_comb
    begin
        bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        main_d = main_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        // firmware write path; host mirrors ignore writes
        if (wr_take)
        begin
            case (avs_address)
                mfhf_pkg::OFS_MAIN_CTRL:
                    main_d = ((main_q & ~bmask) | (avs_writedata & bmask))
                             & mfhf_pkg::MAIN_CTRL_WMASK;
                mfhf_pkg::OFS_CTRL_TWO:
                    ctrl_d = ((ctrl_q & ~bmask) | (avs_writedata & bmask))
                             & mfhf_pkg::CTRL_TWO_WMASK;
                mfhf_pkg::OFS_FWD_MASK:
                    mask_d = ((mask_q & ~bmask) | (avs_writedata & bmask))
                             & mfhf_pkg::FWD_MASK_WMASK;
                default:
                begin
                    main_d = main_q;
                end
            endcase
        end
    end

    always_comb
    begin
        // host view reads the same flops
        case (avs_address)
            mfhf_pkg::OFS_MAIN_CTRL: rsel = main_q;
            mfhf_pkg::OFS_CTRL_TWO: rsel = ctrl_q;
            mfhf_pkg::OFS_FWD_MASK: rsel = mask_q;
            mfhf_pkg::OFS_HOST_CTRL_TWO: rsel = ctrl_q;
            mfhf_pkg::OFS_HOST_FWD_MASK: rsel = mask_q;
            default: rsel = 32'h0000_0000;
        endcase
        rdata_d = (avs_read && state_q == mfhf_pkg::MFHF_IDLE) ? rsel : rdata_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_q <= mfhf_pkg::MFHF_IDLE;
            main_q <= mfhf_pkg::MAIN_CTRL_RST;
            ctrl_q <= mfhf_pkg::CTRL_TWO_RST;
            mask_q <= mfhf_pkg::FWD_MASK_RST;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            main_q <= main_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata = rdata_q;

    assign flex_port_filter_4_mode = ctrl_q[mfhf_pkg::POS_MODE4 +: 2];
    assign flex_port_filter_5_mode = ctrl_q[mfhf_pkg::POS_MODE5 +: 2];
    assign port_side_select = {ctrl_q[mfhf_pkg::BIT_SIDE5], ctrl_q[mfhf_pkg::BIT_SIDE4]};
    assign low_ipv6_addr_filter = ctrl_q[mfhf_pkg::POS_LOW_IPV6 +: 4];
    assign icmpv6_filter_en = ctrl_q[mfhf_pkg::BIT_ICMPV6];
    assign ipv4_control_msg_filter = ctrl_q[mfhf_pkg::BIT_ICMPV4];
    assign recv_to_firmware_enable = main_q[mfhf_pkg::BIT_RECV_EN];
    assign host_forward_global_enable = main_q[mfhf_pkg::BIT_HOST_GLOBAL];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_flex
            mfhf_port_mode u_mode (
                .mode(ctrl_q[2*gi +: 2]),
                .side_src(port_side_select[gi]),
                .dst_hit(flex_dst_hit[gi]),
                .src_hit(flex_src_hit[gi]),
                .pkt_udp(pkt_udp),
                .pkt_tcp(pkt_tcp),
                .hit(flex_hit[gi])
            );
        end
    endgenerate

    always_comb
    begin
        en_vec = {mfhf_pkg::NFILT{1'b1}};
        en_vec[mfhf_pkg::HIT_LOW_IPV6 +: 4] = low_ipv6_addr_filter;
        en_vec[mfhf_pkg::HIT_ICMPV4] = ipv4_control_msg_filter;
        hit_gated = filter_hit & en_vec;
        // flex ports 4 and 5 decided locally
        hit_gated[mfhf_pkg::HIT_FLEX4 +: 2] = flex_hit;
    end

    mfhf_fwd_decide u_decide (
        .mclk(mclk),
        .rstn(rstn),
        .pkt_valid(pkt_valid),
        .hits(hit_gated),
        .icmpv6_hit(icmpv6_hit && icmpv6_filter_en),
        .fwd_mask(mask_q[mfhf_pkg::NFILT-1:0]),
        .recv_en(recv_to_firmware_enable),
        .host_global_en(host_forward_global_enable),
        .decision_valid(decision_valid),
        .fw_route(fw_route),
        .host_copy(host_copy)
    );

    a_wait_first: assert property (@(posedge mclk) disable iff (!rstn)
        req && state_q == mfhf_pkg::MFHF_IDLE |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_write_ctrl: assert property (@(posedge mclk) disable iff (!rstn)
        wr_take && avs_address == mfhf_pkg::OFS_CTRL_TWO && avs_byteenable == 4'hF
        |=> ctrl_q == ($past(avs_writedata) & mfhf_pkg::CTRL_TWO_WMASK))
        else $error("control write not stored");
    a_mirror_ctrl: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address == mfhf_pkg::OFS_HOST_CTRL_TWO
        |-> avs_readdata == ctrl_q)
        else $error("host control mirror mismatch");
    a_mirror_mask: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address == mfhf_pkg::OFS_HOST_FWD_MASK
        |-> avs_readdata == mask_q)
        else $error("host mask mirror mismatch");
    a_host_ro: assert property (@(posedge mclk) disable iff (!rstn)
        wr_take && (avs_address == mfhf_pkg::OFS_HOST_CTRL_TWO
                    || avs_address == mfhf_pkg::OFS_HOST_FWD_MASK)
        |=> $stable(ctrl_q) && $stable(mask_q))
        else $error("host mirror accepted a write");
    a_flex4_off: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_4_mode == mfhf_pkg::MODE_OFF |-> !hit_gated[mfhf_pkg::HIT_FLEX4])
        else $error("disabled flex port 4 hit");
    a_flex5_side: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_5_mode == mfhf_pkg::MODE_BOTH && pkt_udp && port_side_select[1]
        |-> hit_gated[mfhf_pkg::HIT_FLEX4+1] == flex_src_hit[1])
        else $error("flex port 5 side select wrong");
    a_lowip_en: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[mfhf_pkg::HIT_LOW_IPV6 +: 4] == (filter_hit[mfhf_pkg::HIT_LOW_IPV6 +: 4]
                                                   & low_ipv6_addr_filter))
        else $error("low IPv6 enable not applied");
    a_icmp4_en: assert property (@(posedge mclk) disable iff (!rstn)
        !ipv4_control_msg_filter |-> !hit_gated[mfhf_pkg::HIT_ICMPV4])
        else $error("disabled IPv4 ICMP hit");
    a_write_main: assert property (@(posedge mclk) disable iff (!rstn)
        wr_take && avs_address == mfhf_pkg::OFS_MAIN_CTRL && avs_byteenable == 4'hF
        |=> main_q == ($past(avs_writedata) & mfhf_pkg::MAIN_CTRL_WMASK))
        else $error("main control write not stored");
    a_write_mask: assert property (@(posedge mclk) disable iff (!rstn)
        wr_take && avs_address == mfhf_pkg::OFS_FWD_MASK && avs_byteenable == 4'hF
        |=> mask_q == ($past(avs_writedata) & mfhf_pkg::FWD_MASK_WMASK))
        else $error("forward mask write not stored");
    a_regs_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !wr_take
        |=> $stable(main_q) && $stable(ctrl_q) && $stable(mask_q))
        else $error("register changed without a write");
    a_read_main: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address == mfhf_pkg::OFS_MAIN_CTRL
        |-> avs_readdata == main_q)
        else $error("main control read mismatch");
    a_read_ctrl: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address == mfhf_pkg::OFS_CTRL_TWO
        |-> avs_readdata == ctrl_q)
        else $error("control read mismatch");
    a_read_mask: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address == mfhf_pkg::OFS_FWD_MASK
        |-> avs_readdata == mask_q)
        else $error("forward mask read mismatch");
    a_read_unmapped: assert property (@(posedge mclk) disable iff (!rstn)
        avs_read && !avs_waitrequest && avs_address != mfhf_pkg::OFS_MAIN_CTRL
        && avs_address != mfhf_pkg::OFS_CTRL_TWO && avs_address != mfhf_pkg::OFS_FWD_MASK
        && avs_address != mfhf_pkg::OFS_HOST_CTRL_TWO
        && avs_address != mfhf_pkg::OFS_HOST_FWD_MASK
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_read_stable: assert property (@(posedge mclk) disable iff (!rstn)
        !(avs_read && state_q == mfhf_pkg::MFHF_IDLE)
        |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_wait_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !avs_read && !avs_write |-> !avs_waitrequest)
        else $error("wait raised with no request");
    a_reset_regs: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(rstn) |-> main_q == mfhf_pkg::MAIN_CTRL_RST && ctrl_q == mfhf_pkg::CTRL_TWO_RST
        && mask_q == mfhf_pkg::FWD_MASK_RST)
        else $error("registers not cleared by reset");
    a_reset_outputs: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(rstn) |-> !decision_valid && !fw_route && !host_copy
        && avs_readdata == 32'h0000_0000)
        else $error("outputs not cleared by reset");
    a_flex4_udp: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_4_mode == mfhf_pkg::MODE_UDP && !pkt_udp
        |-> !hit_gated[mfhf_pkg::HIT_FLEX4])
        else $error("flex port 4 UDP mode hit a non-UDP packet");
    a_flex4_tcp: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_4_mode == mfhf_pkg::MODE_TCP && !pkt_tcp
        |-> !hit_gated[mfhf_pkg::HIT_FLEX4])
        else $error("flex port 4 TCP mode hit a non-TCP packet");
    a_flex5_off: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_5_mode == mfhf_pkg::MODE_OFF
        |-> !hit_gated[mfhf_pkg::HIT_FLEX4+1])
        else $error("disabled flex port 5 hit");
    a_flex5_udp: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_5_mode == mfhf_pkg::MODE_UDP && !pkt_udp
        |-> !hit_gated[mfhf_pkg::HIT_FLEX4+1])
        else $error("flex port 5 UDP mode hit a non-UDP packet");
    a_flex4_dst: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_4_mode == mfhf_pkg::MODE_BOTH && pkt_tcp && !port_side_select[0]
        |-> hit_gated[mfhf_pkg::HIT_FLEX4] == flex_dst_hit[0])
        else $error("flex port 4 destination select wrong");
    a_flex4_src: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_4_mode == mfhf_pkg::MODE_BOTH && pkt_tcp && port_side_select[0]
        |-> hit_gated[mfhf_pkg::HIT_FLEX4] == flex_src_hit[0])
        else $error("flex port 4 source select wrong");
    a_flex5_dst: assert property (@(posedge mclk) disable iff (!rstn)
        flex_port_filter_5_mode == mfhf_pkg::MODE_BOTH && pkt_tcp && !port_side_select[1]
        |-> hit_gated[mfhf_pkg::HIT_FLEX4+1] == flex_dst_hit[1])
        else $error("flex port 5 destination select wrong");
    a_icmp6_route: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && recv_to_firmware_enable && icmpv6_hit && icmpv6_filter_en
        |=> fw_route)
        else $error("ICMPv6 packet not routed to firmware");
    a_icmp6_off: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && !icmpv6_filter_en && !(|hit_gated)
        |=> !fw_route)
        else $error("packet routed with no filter hit");
    a_icmp4_pass: assert property (@(posedge mclk) disable iff (!rstn)
        ipv4_control_msg_filter
        |-> hit_gated[mfhf_pkg::HIT_ICMPV4] == filter_hit[mfhf_pkg::HIT_ICMPV4])
        else $error("enabled IPv4 ICMP hit lost");
    a_pass_flex: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[4:0] == filter_hit[4:0])
        else $error("flex hits not passed on");
    a_pass_rmcp_arp: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[8:5] == filter_hit[8:5])
        else $error("remote port or ARP hits not passed on");
    a_pass_bc_vlan: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[14:9] == filter_hit[14:9])
        else $error("broadcast, neighbor or VLAN hits not passed on");
    a_pass_shared: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[15] == filter_hit[15])
        else $error("shared address hit not passed on");
    a_pass_fp3: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[16] == filter_hit[16])
        else $error("flex port 3 hit not passed on");
    a_pass_anm: assert property (@(posedge mclk) disable iff (!rstn)
        hit_gated[17] == filter_hit[17])
        else $error("all-nodes multicast hit not passed on");
    a_host_mask_off: assert property (@(posedge mclk) disable iff (!rstn)
        pkt_valid && !(|(hit_gated & mask_q[mfhf_pkg::NFILT-1:0]))
        |=> !host_copy)
        else $error("host copy without a masked hit");
endmodule // mfhf_top
`default_nettype wire

// ==== mgmt_filter_host_forward_ctrl_test.sv ====
// Self-checking bench for the filter control and host-forward bank
`timescale 1ns/1ps
`default_nettype none
module mgmt_filter_host_forward_ctrl_test;
    logic mclk, rstn, avs_read, avs_write, avs_waitrequest, pkt_valid, pkt_udp, pkt_tcp;
    logic icmpv6_hit, icmpv6_filter_en, ipv4_flt, recv_en, glob_en, dec_v, fw_route, host_copy;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, mc_s, c2_s, mk_s;
    logic [3:0] avs_byteenable, low_ipv6;
    logic [24:0] filter_hit;
    logic [1:0] dst_hit, src_hit, mode4, mode5, side;
    int n_fail = 0;
    int tests_run = 0;
    mfhf_top mfhf_top_i (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pkt_valid(pkt_valid), .filter_hit(filter_hit),
        .flex_dst_hit(dst_hit), .flex_src_hit(src_hit), .pkt_udp(pkt_udp), .pkt_tcp(pkt_tcp),
        .icmpv6_hit(icmpv6_hit), .flex_port_filter_4_mode(mode4),
        .flex_port_filter_5_mode(mode5), .port_side_select(side),
        .low_ipv6_addr_filter(low_ipv6), .icmpv6_filter_en(icmpv6_filter_en),
        .ipv4_control_msg_filter(ipv4_flt), .recv_to_firmware_enable(recv_en),
        .host_forward_global_enable(glob_en), .decision_valid(dec_v),
        .fw_route(fw_route), .host_copy(host_copy));
    mfhf_pkt_model mfhf_pkt_model_i (.mclk(mclk), .pkt_valid(pkt_valid),
        .filter_hit(filter_hit), .flex_dst_hit(dst_hit), .flex_src_hit(src_hit),
        .pkt_udp(pkt_udp), .pkt_tcp(pkt_tcp), .icmpv6_hit(icmpv6_hit));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic summarize;
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h saw %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50)
        begin
            n_fail++;
            summarize();
        end
    endtask
    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
        input logic [3:0] be, input logic [31:0] wm);
        for (int i = 0; i < 4; i++)
            if (be[i])
                o[8*i +: 8] = d[8*i +: 8];
        return o & wm;
    endfunction
    // Shadow follows only the firmware-side addresses; mirrors stay read-only
    task automatic wreg(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
        if (a == mfhf_pkg::OFS_MAIN_CTRL)
            mc_s = mrg(mc_s, d, be, mfhf_pkg::MAIN_CTRL_WMASK);
        if (a == mfhf_pkg::OFS_CTRL_TWO)
            c2_s = mrg(c2_s, d, be, mfhf_pkg::CTRL_TWO_WMASK);
        if (a == mfhf_pkg::OFS_FWD_MASK)
            mk_s = mrg(mk_s, d, be, mfhf_pkg::FWD_MASK_WMASK);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk("readdata", q, e);
    endtask
    task automatic rall;
        rchk(mfhf_pkg::OFS_MAIN_CTRL, mc_s);
        rchk(mfhf_pkg::OFS_CTRL_TWO, c2_s);
        rchk(mfhf_pkg::OFS_FWD_MASK, mk_s);
        rchk(mfhf_pkg::OFS_HOST_CTRL_TWO, c2_s);
        rchk(mfhf_pkg::OFS_HOST_FWD_MASK, mk_s);
        rchk(16'h0100, 32'h0000_0000);
    endtask
    function automatic logic [1:0] exp_dec(input logic [31:0] v);
        logic [24:0] h;
        logic [1:0] md;
        h = v[31:7];
        h[21:18] = h[21:18] & c2_s[15:12];
        h[24] = h[24] & c2_s[18];
        for (int f = 0; f < 2; f++)
        begin
            md = c2_s[2*f +: 2];
            h[22+f] = (c2_s[8+f] ? v[3+f] : v[5+f]) & (v[2] & md[0] | v[1] & md[1]);
        end
        return {mc_s[17] & ((|h) | v[0] & c2_s[17]), mc_s[17] & mc_s[21] & (|(h & mk_s[24:0]))};
    endfunction
    task automatic pkt;
        logic [31:0] v;
        v[31:7] = (25'h1 << ($urandom % 26)) | (25'h1 << ($urandom % 26));
        v[6:0] = 7'($urandom);
        mfhf_pkt_model_i.send(v);
        #1;
        chk("decision", {dec_v, fw_route, host_copy}, {1'b1, exp_dec(v)});
        @(posedge mclk);
        #1;
        chk("decision_end", {dec_v, fw_route, host_copy}, 3'h0);
    endtask
    initial
    begin
        rstn = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {mc_s, c2_s, mk_s} = '0;
        void'($urandom(98404));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rall();
        for (int k = 0; k < 16; k++)
        begin
            // Every code pair of both port filter modes gets its turn
            wreg(mfhf_pkg::OFS_CTRL_TWO, {$urandom} & ~32'hF | k, 4'($urandom) | 4'h1);
            wreg(mfhf_pkg::OFS_FWD_MASK, $urandom, 4'($urandom));
            wreg(mfhf_pkg::OFS_MAIN_CTRL, $urandom | (k < 12 ? 32'h0022_0000 : 0), 4'hF);
            wreg(mfhf_pkg::OFS_HOST_CTRL_TWO, $urandom, 4'hF);
            wreg(mfhf_pkg::OFS_HOST_FWD_MASK, $urandom, 4'hF);
            wreg(16'h0100, $urandom, 4'hF);
            rall();
            chk("ports", {mode4, mode5, side, low_ipv6, icmpv6_filter_en, ipv4_flt, recv_en,
                glob_en}, {c2_s[1:0], c2_s[3:2], c2_s[9:8], c2_s[15:12], c2_s[17], c2_s[18],
                mc_s[17], mc_s[21]});
            repeat (16) pkt();
        end
        summarize();
    end
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end
endmodule // mgmt_filter_host_forward_ctrl_test
`default_nettype wire
